// *** rtl/timer_clock_input_remap.sv ***
/*
 * Timer clock input remapper: routes two timer external clocks from any of
 * 26 remappable pins (or ground) and holds the second PWM disable bit.
 * Assumes one 125 MHz clock, a plain one-cycle strobe register port and
 * pins that are asynchronous to ref_clk.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module timer_clock_input_remap (
    input  wire logic                                 ref_clk,
    input  wire logic                                 resetn,
    input  wire pin_remap_pkg::bus_req_t              bus_req,
    output logic      [pin_remap_pkg::DATA_W-1:0]     rd_data,
    input  wire logic [pin_remap_pkg::PIN_NUM-1:0]    remappable_pin,
    output logic                                      timer_a_external_clock,
    output logic                                      timer_b_external_clock,
    output logic                                      second_pwm_disable
);

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [pin_remap_pkg::SEL_W-1:0]  sel_a;
        logic [pin_remap_pkg::SEL_W-1:0]  sel_b;
        logic                             pwm_dis;
        logic                             clk_a;
        logic                             clk_b;
        logic [pin_remap_pkg::DATA_W-1:0] rdata;
    } remap_state_t;

    remap_state_t                      state_reg;
    remap_state_t                      state_next;
    logic [pin_remap_pkg::PIN_NUM-1:0] pin_sync;

    // Pick one synchronised pin, ground for the tie-off and unused codes
    function automatic logic route_pin(
        input logic [pin_remap_pkg::PIN_NUM-1:0] pins,
        input logic [pin_remap_pkg::SEL_W-1:0]   sel
    );
        logic res;
        res = 1'b0;
        if (sel <= pin_remap_pkg::SEL_LAST_PIN) begin
            res = pins[sel];
        end
        return res;
    endfunction

    // Read view of the clock select register, reserved bits zero
    function automatic logic [pin_remap_pkg::DATA_W-1:0] select_view(
        input logic [pin_remap_pkg::SEL_W-1:0] sa,
        input logic [pin_remap_pkg::SEL_W-1:0] sb
    );
        logic [pin_remap_pkg::DATA_W-1:0] v;
        v = pin_remap_pkg::DATA_ZERO;
        v[pin_remap_pkg::SEL_A_LSB +: pin_remap_pkg::SEL_W] = sa;
        v[pin_remap_pkg::SEL_B_LSB +: pin_remap_pkg::SEL_W] = sb;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_sync_bank u_sync (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .pin_async (remappable_pin),
        .pin_sync  (pin_sync)
    );

    // ------------------------------------------------------------------
    // Next state: register writes, reads and clock routing
    // ------------------------------------------------------------------
    always_comb begin
        state_next       = state_reg;
        state_next.rdata = pin_remap_pkg::DATA_ZERO;
        if (bus_req.wr) begin
            if (bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT) begin
                state_next.sel_a = bus_req.wdata[pin_remap_pkg::SEL_A_LSB +:
                                                 pin_remap_pkg::SEL_W];
                state_next.sel_b = bus_req.wdata[pin_remap_pkg::SEL_B_LSB +:
                                                 pin_remap_pkg::SEL_W];
            end
            if (bus_req.addr == pin_remap_pkg::OFS_PERIPH_DIS) begin
                state_next.pwm_dis = bus_req.wdata[pin_remap_pkg::PWM_DIS_BIT];
            end
        end
        if (bus_req.rd) begin
            if (bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT) begin
                state_next.rdata = select_view(state_reg.sel_a, state_reg.sel_b);
            end else if (bus_req.addr == pin_remap_pkg::OFS_PERIPH_DIS) begin
                state_next.rdata[pin_remap_pkg::PWM_DIS_BIT] = state_reg.pwm_dis;
            end
        end
        // pins 0 to 25 or ground, linear pin map
        state_next.clk_a = route_pin(pin_sync, state_reg.sel_a);
        state_next.clk_b = route_pin(pin_sync, state_reg.sel_b);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg.sel_a   <= pin_remap_pkg::SEL_RESET;
            state_reg.sel_b   <= pin_remap_pkg::SEL_RESET;
            state_reg.pwm_dis <= pin_remap_pkg::PWM_DIS_RESET;
            state_reg.clk_a   <= 1'b0;
            state_reg.clk_b   <= 1'b0;
            state_reg.rdata   <= pin_remap_pkg::DATA_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign rd_data                = state_reg.rdata;
    assign timer_a_external_clock = state_reg.clk_a;
    assign timer_b_external_clock = state_reg.clk_b;
    assign second_pwm_disable     = state_reg.pwm_dis;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_pwm_disable_write: assert property (
        (bus_req.wr && bus_req.addr == pin_remap_pkg::OFS_PERIPH_DIS)
        |=> second_pwm_disable == $past(bus_req.wdata[pin_remap_pkg::PWM_DIS_BIT])
    ) else $error("PWM disable output does not follow written bit");

    a_sel_a_write: assert property (
        (bus_req.wr && bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT && !bus_req.rd)
        ##1 bus_req.rd && bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT && !bus_req.wr
        |=> rd_data[4:0] == $past(bus_req.wdata[4:0], 2)
    ) else $error("First selector readback differs from written value");

    a_pin25_route: assert property (
        (state_reg.sel_a == pin_remap_pkg::SEL_LAST_PIN) [*4]
        |-> timer_a_external_clock == $past(remappable_pin[pin_remap_pkg::SEL_LAST_PIN], 3)
    ) else $error("Code 11001 does not route pin 25");

    a_ground_tie: assert property (
        state_reg.sel_b == pin_remap_pkg::SEL_GROUND |=> !timer_b_external_clock
    ) else $error("Code 11111 does not ground the clock");

    a_pin0_route: assert property (
        (state_reg.sel_b == 5'h00) [*4] |-> timer_b_external_clock == $past(remappable_pin[0], 3)
    ) else $error("Code 00000 does not route pin 0");

    a_reserved_zero: assert property (
        bus_req.rd && bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT
        |=> rd_data[15:13] == 3'h0 && rd_data[7:5] == 3'h0
            && rd_data[12:8] == $past(state_reg.sel_b)
    ) else $error("Select register readback layout wrong");

    c_route_pin: cover property ((state_reg.sel_a == 5'h03) [*4] ##1 timer_a_external_clock);
    c_pwm_off:   cover property ($rose(second_pwm_disable));
    c_sel_read:  cover property (bus_req.rd && bus_req.addr == pin_remap_pkg::OFS_CLK_SELECT);

endmodule // timer_clock_input_remap

// *** rtl/pin_remap_pkg.sv ***
/*
 * Package for the timer clock input remapper: register offsets, field
 * positions, reset values, selector codes and the bus request carrier.
 * Assumes a single 125 MHz clock domain and a 16-bit register port.
 */
package pin_remap_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 16;
    localparam int SEL_W    = 5;
    localparam int PIN_NUM  = 26;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CLK_SELECT  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_DIS  = 8'h04;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SEL_A_LSB  = 0;
    localparam int SEL_B_LSB  = 8;
    localparam int PWM_DIS_BIT = 4;

    // ------------------------------------------------------------------
    // Selector codes and reset values
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_GROUND    = 5'h1f;
    localparam logic [SEL_W-1:0] SEL_LAST_PIN  = 5'h19;
    localparam logic [SEL_W-1:0] SEL_RESET     = 5'h1f;
    localparam logic             PWM_DIS_RESET = 1'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO    = 16'h0000;

    // ------------------------------------------------------------------
    // Register port request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

endpackage

// *** rtl/pin_sync_bank.sv ***
/*
 * Two-flop synchroniser bank for the remappable pins.
 * Assumes the pins are asynchronous to ref_clk; only stage two is read out.
 */
`timescale 1ns/1ps
module pin_sync_bank (
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    input  wire logic [pin_remap_pkg::PIN_NUM-1:0] pin_async,
    output logic      [pin_remap_pkg::PIN_NUM-1:0] pin_sync
);

    typedef struct packed {
        logic [pin_remap_pkg::PIN_NUM-1:0] stage1;
        logic [pin_remap_pkg::PIN_NUM-1:0] stage2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // ------------------------------------------------------------------
    // Next state: shift pins through two stages
    // ------------------------------------------------------------------
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = pin_async;
        state_next.stage2 = state_reg.stage1;
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_sync = state_reg.stage2;

endmodule // pin_sync_bank

// *** verif/ext_clock_sources.sv ***
/*
 * External clock sources on the remappable pins: a shift pattern gives
 * each pin its own waveform. Assumes ref_clk and active-low resetn.
 */
`timescale 1ns/1ps
module ext_clock_sources (
    input  wire logic                                 ref_clk,
    input  wire logic                                 resetn,
    input  wire logic                                 hold,
    output logic      [pin_remap_pkg::PIN_NUM-1:0]    pins
);
    logic [31:0] shift_reg;

    // Pattern advances each cycle, or stands still for a slow source
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= 32'h9e3779b9;
        end else if (!hold) begin
            shift_reg <= {shift_reg[30:0], shift_reg[31] ^ shift_reg[21] ^ shift_reg[0]};
        end
    end

    assign pins = shift_reg[pin_remap_pkg::PIN_NUM-1:0];
endmodule // ext_clock_sources

// *** verif/timer_clock_input_remap_tb.sv ***
/*
 * Self-checking bench for the timer clock input remapper.
 * Assumes the pin source model and the design package are compiled first.
 */
`timescale 1ns/1ps
module timer_clock_input_remap_tb;
    logic                    ref_clk;
    logic                    resetn;
    logic                    hold;
    pin_remap_pkg::bus_req_t bus_req;
    logic [15:0]             rd_data;
    logic [25:0]             pins;
    logic [25:0]             p1, p2, p3;
    logic                    clk_a, clk_b, pwm_off;
    int                      errors, num_checks, cycles;

    ext_clock_sources src (.ref_clk(ref_clk), .resetn(resetn), .hold(hold), .pins(pins));
    timer_clock_input_remap uut (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
        .rd_data(rd_data), .remappable_pin(pins), .timer_a_external_clock(clk_a),
        .timer_b_external_clock(clk_b), .second_pwm_disable(pwm_off));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Pin history three edges deep: two sync flops plus the output flop
    always @(posedge ref_clk) begin
        p1 <= pins;
        p2 <= p1;
        p3 <= p2;
    end

    // Cycle ceiling against a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Compare, bus and verdict tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data, exp, what);
    endtask

    // Write then read back with no idle cycle between the two strobes
    task automatic write_read(input logic [7:0] a, input logic [15:0] d,
                              input logic [15:0] exp, input string what);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data, exp, what);
    endtask

    // Both timer clocks follow their selected pins three edges late
    task automatic route(input logic [4:0] sa, input logic [4:0] sb);
        repeat (4) @(negedge ref_clk);
        repeat (8) begin
            @(negedge ref_clk);
            check_bit(clk_a, (sa < 26) ? p3[sa] : 1'b0, "timer a clock");
            check_bit(clk_b, (sb < 26) ? p3[sb] : 1'b0, "timer b clock");
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        hold = 1'b0;
        bus_req = '0;
        errors = 0;
        num_checks = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        reg_read(8'h00, 16'h1f1f, "select reset");
        reg_read(8'h04, 16'h0000, "disable reset");
        route(5'h1f, 5'h1f);
        // Every pin code on both selectors, opposite ends at once
        for (int i = 0; i < 26; i++) begin
            write_read(8'h00, {3'h0, 5'(25 - i), 3'h0, 5'(i)},
                       {3'h0, 5'(25 - i), 3'h0, 5'(i)}, "select readback");
            route(5'(i), 5'(25 - i));
        end
        // Stalled sources: routed clocks stand still on pins 25 and 0
        hold <= 1'b1;
        route(5'h19, 5'h00);
        hold <= 1'b0;
        reg_write(8'h00, 16'hffff);
        reg_read(8'h00, 16'h1f1f, "reserved bits");
        route(5'h1f, 5'h1f);
        reg_write(8'h00, 16'h1a1e);
        route(5'h1e, 5'h1a);
        // Second PWM disable set and cleared
        reg_write(8'h04, 16'h0010);
        #1;
        check_bit(pwm_off, 1'b1, "pwm disabled");
        reg_read(8'h04, 16'h0010, "disable readback");
        reg_write(8'h04, 16'h0000);
        #1;
        check_bit(pwm_off, 1'b0, "pwm enabled");
        // Unmapped address: write ignored, read zero
        reg_write(8'h08, 16'h0101);
        reg_read(8'h08, 16'h0000, "unmapped read");
        reg_read(8'h00, 16'h1a1e, "select kept");
        give_verdict();
    end
endmodule // timer_clock_input_remap_tb
